// ---- rtl/smc_pkg.sv ----
/*
 * Shared constants and carrier types of the synthesizer output and mode control.
 * Assumes a 10 MHz core clock and an APB master with 32-bit data.
 */
package smc_pkg;
	localparam int          CLK_PERIOD_NS  = 100;
	localparam int          LOCK_TIME_US   = 100;
	localparam int          LOCK_CYC       = (LOCK_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int          REF_GAP_NS     = 2000;
	localparam int          REF_GAP_CYC    = REF_GAP_NS / CLK_PERIOD_NS;
	localparam int          INIT_TOGGLES   = 3;
	localparam int          NUM_MODES      = 4;

	localparam logic [7:0]  ADDR_RATIO0    = 8'h00;
	localparam logic [7:0]  ADDR_MODAL     = 8'h10;
	localparam logic [7:0]  ADDR_GLOBAL    = 8'h14;
	localparam logic [7:0]  ADDR_STATUS    = 8'h18;
	localparam logic [7:0]  ADDR_EFF       = 8'h1C;

	localparam int          MODAL_W        = 4;
	localparam int          MOD_LSB        = 0;
	localparam int          AUX_LSB        = 2;
	localparam logic [31:0] RATIO_RST      = 32'h0010_0000;
	localparam logic [15:0] MODAL_RST      = 16'h0000;
	localparam logic [7:0]  GLOBAL_RST     = 8'h08;

	localparam logic [1:0]  AUX_REF        = 2'h0;
	localparam logic [1:0]  AUX_SYN        = 2'h2;
	localparam logic [1:0]  AUX_LOCK       = 2'h3;

	localparam logic [2:0]  FN_DIS_MAIN    = 3'h0;
	localparam logic [2:0]  FN_DIS_AUX     = 3'h1;
	localparam logic [2:0]  FN_DIS_BOTH    = 3'h2;
	localparam logic [2:0]  FN_MOD_EN      = 3'h3;
	localparam logic [2:0]  FN_FORCE_SYN   = 3'h7;

	typedef struct packed {
		logic       field_programmed;
		logic [1:0] reference_divider_select;
		logic [2:0] special_pin_function;
		logic       clock_on_unlock_enable;
		logic       lock_indicator_config;
	} smc_global_t;

	typedef struct packed {
		logic       modifier_applied;
		logic [1:0] active_mode;
		logic       init_done;
		logic       locked;
	} smc_status_t;

	typedef enum logic [2:0] {
		ST_INIT = 3'b001,
		ST_WAIT = 3'b010,
		ST_LOCK = 3'b100
	} smc_state_t;
endpackage

// ---- rtl/smc_top.sv ----
/*
 * Mode pin decode, ratio forming, lock sequencing and output routing
 * of a fractional-N clock synthesizer, with an APB register file.
 * Assumes pins, reference and synthesized clocks arrive sampled on core_clk.
 */
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - Mode pins pick ratio and modal set
// - Effective ratio, modifier, divider-corrected fractional value
// - Main output low while unlocked unless overridden
// - Codes 000/010: special pin tri-states main
// - Aux pin carries exactly one source
// - Aux select: 00 ref, 10 synth, 11 lock
// - Lock indicator driver set by global config
// - Config 0 push-pull high unlocked; 1 open-drain
// - Aux synth copy not phase aligned
// - Codes 001/010: special pin tri-states aux
// - Disable codes: pin low enables, high disables
// - Code 011: pin high alone applies modifier
// - Modifier shifts right by 1 to 4
// - Code 111: pin high forces synth aux source
// - No runt pulses when gating or switching
// - Lock source switching may give partial period
// - Mode pin change forces temporary unlock
// - Codes 011-110: special pin change may unlock
// - Reference discontinuity causes unlock
// - Field-programmed parts need three mode toggles
// - Configured clock appears after lock time
module smc_top (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        mode_select_low_pin,
	input  wire logic        mode_select_high_pin,
	input  wire logic        special_function_pin,
	input  wire logic        internal_reference_clock,
	input  wire logic        synth_clk,
	output logic [33:0]      frac_n_value,
	output logic             main_clk_out,
	output logic             main_clk_oe_b,
	output logic             aux_out,
	output logic             aux_oe_b
);
	logic [31:0]          ratio_r [smc_pkg::NUM_MODES];
	logic [15:0]          modal_r;
	smc_pkg::smc_global_t glob_r;
	smc_pkg::smc_status_t stat;
	smc_pkg::smc_state_t  state_r;
	logic [1:0]           mode_r;
	logic                 sp_r;
	logic [1:0]           toggles_r;
	logic [15:0]          lock_cnt_r;
	logic [15:0]          gap_cnt_r;
	logic                 ref_d_r;
	logic                 main_gate_r;
	logic                 main_hiz_r;
	logic                 aux_en_r;
	logic [1:0]           aux_src_r;
	logic                 syn_d_r;
	logic [31:0]          eff_ratio;
	logic [1:0]           mode_now;
	logic [3:0]           modal_sel;
	logic                 mod_apply;
	logic [1:0]           aux_want;
	logic                 relock;
	logic                 ref_lost;
	logic                 init_done;
	logic                 locked;
	logic                 wr_en;
	logic                 clk_allowed;

	function automatic logic dis_main(input logic [2:0] fn);
		dis_main = (fn == smc_pkg::FN_DIS_MAIN) || (fn == smc_pkg::FN_DIS_BOTH);
	endfunction

	function automatic logic dis_aux(input logic [2:0] fn);
		dis_aux = (fn == smc_pkg::FN_DIS_AUX) || (fn == smc_pkg::FN_DIS_BOTH);
	endfunction

	// Codes whose pin change reconfigures the loop
	function automatic logic sp_relocks(input logic [2:0] fn);
		sp_relocks = (fn >= smc_pkg::FN_MOD_EN) && (fn != smc_pkg::FN_FORCE_SYN);
	endfunction

	function automatic logic [31:0] apply_mod(input logic [31:0] r, input logic en,
		input logic [1:0] sel);
		apply_mod = en ? (r >> ({1'b0, sel} + 3'h1)) : r;
	endfunction

	assign mode_now  = {mode_select_high_pin, mode_select_low_pin};
	assign modal_sel = modal_r[mode_r * smc_pkg::MODAL_W +: smc_pkg::MODAL_W];
	// Pin is the only enable; reserved codes never apply it
	assign mod_apply = (glob_r.special_pin_function == smc_pkg::FN_MOD_EN) && sp_r;
	assign eff_ratio = apply_mod(ratio_r[mode_r], mod_apply,
		modal_sel[smc_pkg::MOD_LSB +: 2]);
	assign aux_want  = (glob_r.special_pin_function == smc_pkg::FN_FORCE_SYN) && sp_r
		? smc_pkg::AUX_SYN : modal_sel[smc_pkg::AUX_LSB +: 2];

	// Divided reference means the loop must multiply further
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			frac_n_value <= 34'h0_0000_0000;
		end else begin
			case (glob_r.reference_divider_select)
				2'h0:    frac_n_value <= {eff_ratio, 2'h0};
				2'h1:    frac_n_value <= {1'b0, eff_ratio, 1'b0};
				default: frac_n_value <= {2'h0, eff_ratio};
			endcase
		end
	end

	// Pin sampling
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_r  <= 2'h0;
			sp_r    <= 1'b0;
			ref_d_r <= 1'b0;
			syn_d_r <= 1'b0;
		end else begin
			mode_r  <= mode_now;
			sp_r    <= special_function_pin;
			ref_d_r <= internal_reference_clock;
			syn_d_r <= synth_clk;
		end
	end

	// Reference watchdog: no edge for a while counts as a discontinuity
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			gap_cnt_r <= 16'h0000;
		end else if (internal_reference_clock != ref_d_r) begin
			gap_cnt_r <= 16'h0000;
		end else if (!ref_lost) begin
			gap_cnt_r <= gap_cnt_r + 16'h0001;
		end
	end
	assign ref_lost = (gap_cnt_r >= 16'(smc_pkg::REF_GAP_CYC));

	assign relock = (mode_now != mode_r)
		|| (sp_relocks(glob_r.special_pin_function) && special_function_pin != sp_r)
		|| ref_lost;

	// Initialisation toggles on the mode pins
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			toggles_r <= 2'h0;
		end else if ((mode_now != mode_r) && (toggles_r != 2'(smc_pkg::INIT_TOGGLES))) begin
			toggles_r <= toggles_r + 2'h1;
		end
	end
	assign init_done = !glob_r.field_programmed
		|| (toggles_r == 2'(smc_pkg::INIT_TOGGLES));

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r    <= smc_pkg::ST_INIT;
			lock_cnt_r <= 16'h0000;
		end else begin
			case (state_r)
				smc_pkg::ST_INIT: begin
					lock_cnt_r <= 16'h0000;
					if (init_done && !relock) begin
						state_r <= smc_pkg::ST_WAIT;
					end
				end
				smc_pkg::ST_WAIT: begin
					if (relock || !init_done) begin
						lock_cnt_r <= 16'h0000;
					end else if (lock_cnt_r == 16'(smc_pkg::LOCK_CYC - 1)) begin
						state_r <= smc_pkg::ST_LOCK;
					end else begin
						lock_cnt_r <= lock_cnt_r + 16'h0001;
					end
				end
				smc_pkg::ST_LOCK: begin
					lock_cnt_r <= 16'h0000;
					if (relock) begin
						state_r <= smc_pkg::ST_WAIT;
					end
				end
				default: begin
					state_r    <= smc_pkg::ST_INIT;
					lock_cnt_r <= 16'h0000;
				end
			endcase
		end
	end
	assign locked      = (state_r == smc_pkg::ST_LOCK);
	assign clk_allowed = locked || (glob_r.clock_on_unlock_enable && init_done);

	// Main gate and tri-state change only while synth clock is low
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			main_gate_r <= 1'b0;
			main_hiz_r  <= 1'b0;
		end else if (!synth_clk) begin
			main_gate_r <= clk_allowed;
			main_hiz_r  <= dis_main(glob_r.special_pin_function) && sp_r;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			main_clk_out  <= 1'b0;
			main_clk_oe_b <= 1'b0;
		end else begin
			main_clk_out  <= synth_clk && main_gate_r && !main_hiz_r;
			main_clk_oe_b <= main_hiz_r;
		end
	end

	// Clock-to-clock switches wait for both clocks low; lock switches go at once
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_src_r <= smc_pkg::AUX_REF;
		end else if (aux_want == 2'h1) begin
			aux_src_r <= aux_src_r;
		end else if (aux_want == smc_pkg::AUX_LOCK || aux_src_r == smc_pkg::AUX_LOCK) begin
			aux_src_r <= aux_want;
		end else if (!internal_reference_clock && !synth_clk) begin
			aux_src_r <= aux_want;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_en_r <= 1'b1;
		end else if (aux_src_r == smc_pkg::AUX_LOCK
			|| (!internal_reference_clock && !synth_clk)) begin
			aux_en_r <= !(dis_aux(glob_r.special_pin_function) && sp_r);
		end
	end

	// Synth copy leaves from the delayed sample, one cycle behind main
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			aux_out  <= 1'b0;
			aux_oe_b <= 1'b0;
		end else if (!aux_en_r) begin
			aux_out  <= 1'b0;
			aux_oe_b <= 1'b1;
		end else begin
			case (aux_src_r)
				smc_pkg::AUX_REF: begin
					aux_out  <= internal_reference_clock;
					aux_oe_b <= 1'b0;
				end
				smc_pkg::AUX_SYN: begin
					aux_out  <= syn_d_r && main_gate_r;
					aux_oe_b <= 1'b0;
				end
				smc_pkg::AUX_LOCK: begin
					aux_out  <= glob_r.lock_indicator_config ? 1'b0 : !locked;
					aux_oe_b <= glob_r.lock_indicator_config && locked;
				end
				default: begin
					aux_out  <= 1'b0;
					aux_oe_b <= 1'b0;
				end
			endcase
		end
	end

	// APB slave, zero wait states
	assign pready = 1'b1;
	assign wr_en  = psel && penable && pwrite;
	assign stat   = '{modifier_applied: mod_apply, active_mode: mode_r,
		init_done: init_done, locked: locked};

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < smc_pkg::NUM_MODES; i++) begin
				ratio_r[i] <= smc_pkg::RATIO_RST;
			end
			modal_r <= smc_pkg::MODAL_RST;
			glob_r  <= smc_pkg::GLOBAL_RST;
		end else if (wr_en) begin
			if (paddr < smc_pkg::ADDR_MODAL && paddr[1:0] == 2'h0) begin
				ratio_r[paddr[3:2]] <= pwdata;
			end else if (paddr == smc_pkg::ADDR_MODAL) begin
				modal_r <= pwdata[15:0];
			end else if (paddr == smc_pkg::ADDR_GLOBAL) begin
				glob_r <= pwdata[7:0];
			end
		end
	end

	always_comb begin
		prdata  = 32'h0000_0000;
		pslverr = 1'b0;
		if (paddr < smc_pkg::ADDR_MODAL && paddr[1:0] == 2'h0) begin
			prdata = ratio_r[paddr[3:2]];
		end else begin
			case (paddr)
				smc_pkg::ADDR_MODAL:  prdata = {16'h0000, modal_r};
				smc_pkg::ADDR_GLOBAL: prdata = {24'h00_0000, glob_r};
				smc_pkg::ADDR_STATUS: prdata = {27'h000_0000, stat};
				smc_pkg::ADDR_EFF:    prdata = eff_ratio;
				default:              pslverr = psel && penable;
			endcase
		end
	end

	AST_MAIN_LOW_UNLOCKED: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!clk_allowed && !synth_clk) |=> ##1 !main_clk_out)
		else $error("main clock not held low while unlocked");

	AST_MAIN_HIZ: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!synth_clk && sp_r && dis_main(glob_r.special_pin_function)) |=> ##1 main_clk_oe_b)
		else $error("main pin not tri-stated by special pin");

	AST_AUX_HIZ: assert property (@(posedge core_clk) disable iff (!rst_b)
		(!internal_reference_clock && !synth_clk && sp_r
		&& dis_aux(glob_r.special_pin_function)) |=> ##1 aux_oe_b)
		else $error("aux pin not tri-stated by special pin");

	AST_MOD_SHIFT: assert property (@(posedge core_clk) disable iff (!rst_b)
		mod_apply |-> eff_ratio == (ratio_r[mode_r] >> ({1'b0, modal_sel[1:0]} + 3'h1)))
		else $error("modifier shift wrong");

	AST_NO_MOD_RESERVED: assert property (@(posedge core_clk) disable iff (!rst_b)
		(glob_r.special_pin_function != smc_pkg::FN_MOD_EN) |-> eff_ratio == ratio_r[mode_r])
		else $error("modifier applied without pin enable");

	AST_RELOCK_MODE: assert property (@(posedge core_clk) disable iff (!rst_b)
		(mode_now != mode_r) |=> !locked [*3])
		else $error("lock kept across mode change");

	AST_REF_LOSS: assert property (@(posedge core_clk) disable iff (!rst_b)
		(internal_reference_clock == ref_d_r) [*8] |-> ##0 (gap_cnt_r != 16'h0000))
		else $error("reference watchdog not counting");

	AST_LOCK_IND_OD: assert property (@(posedge core_clk) disable iff (!rst_b)
		(aux_en_r && aux_src_r == smc_pkg::AUX_LOCK && glob_r.lock_indicator_config)
		|=> (aux_out == 1'b0) && (aux_oe_b == $past(locked)))
		else $error("open-drain lock indicator wrong");

	AST_LOCK_IND_PP: assert property (@(posedge core_clk) disable iff (!rst_b)
		(aux_en_r && aux_src_r == smc_pkg::AUX_LOCK && !glob_r.lock_indicator_config)
		|=> !aux_oe_b && (aux_out == !$past(locked)))
		else $error("push-pull lock indicator wrong");

	AST_INIT_GATE: assert property (@(posedge core_clk) disable iff (!rst_b)
		!init_done |-> !locked)
		else $error("locked before initialisation toggles");
endmodule // smc_top

`default_nettype wire

// ---- testbench/smc_board.sv ----
/*
 * Board-side model: mode and special pins, reference clock and synthesized clock.
 * Assumes the bench requests pin levels in step with core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module smc_board (
	input  wire logic       core_clk,
	input  wire logic [1:0] mode_req,
	input  wire logic       sf_req,
	input  wire logic       ref_run,
	output logic            mode_select_low_pin,
	output logic            mode_select_high_pin,
	output logic            special_function_pin,
	output logic            internal_reference_clock,
	output logic            synth_clk
);
	logic [2:0] phase_r = 3'h0;
	logic [1:0] mode_r  = 2'h0;
	logic       sf_r    = 1'b0;
	logic       ref_r   = 1'b0;

	// Pin levels stay static until the bench asks for a change
	always_ff @(posedge core_clk) begin
		mode_r <= mode_req;
		sf_r   <= sf_req;
	end

	always_ff @(posedge core_clk) begin
		phase_r <= phase_r + 3'h1;
	end

	// Reference runs while ref_run is high; the bench drops ref_run to stop it and show an unlock
	always_ff @(posedge core_clk) begin
		ref_r <= ref_run ? phase_r[2] : 1'b0;
	end

	assign mode_select_low_pin      = mode_r[0];
	assign mode_select_high_pin     = mode_r[1];
	assign special_function_pin     = sf_r;
	assign internal_reference_clock = ref_r;
	assign synth_clk                = phase_r[1];
endmodule // smc_board
`default_nettype wire

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench of the mode and output control, APB tasks and pin sequences.
 * Assumes smc_top and the board model smc_board on one 10 MHz clock.
 */
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
	logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, exp;
	logic        mode_select_low_pin, mode_select_high_pin, special_function_pin;
	logic        internal_reference_clock, synth_clk, sf_req, ref_run;
	logic [1:0]  mode_req;
	logic [33:0] frac_n_value;
	logic        main_clk_out, main_clk_oe_b, aux_out, aux_oe_b;
	int          n_mismatch = 0;
	int          n_tests = 0;
	int          mt, at;
	logic [31:0] ratio [4] = '{32'h0013A92A, 32'h1000_0000, 32'h0020_0000, 32'h0008_0000};
	logic [7:0]  gcode [4] = '{8'hC0, 8'hC4, 8'hC8, 8'hD0};
	logic [1:0]  dis   [4] = '{2'b10, 2'b01, 2'b11, 2'b00};

	smc_top smc_top_inst (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .mode_select_low_pin, .mode_select_high_pin, .special_function_pin,
		.internal_reference_clock, .synth_clk, .frac_n_value, .main_clk_out, .main_clk_oe_b,
		.aux_out, .aux_oe_b);
	smc_board smc_board_inst (.core_clk, .mode_req, .sf_req, .ref_run, .mode_select_low_pin,
		.mode_select_high_pin, .special_function_pin, .internal_reference_clock, .synth_clk);

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		// Only the watchdog ends a wait for the slave
		while (pready !== 1'b1) begin
			@(posedge core_clk);
		end
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pins(input logic [1:0] m, input logic s);
		@(posedge core_clk);
		mode_req <= m;
		sf_req   <= s;
		// Aux enable may wait five cycles for both clocks low, plus the output flop
		repeat (10) @(posedge core_clk);
	endtask

	task automatic wait_lock;
		rd = '0;
		while (rd[0] !== 1'b1) begin
			apb(1'b0, smc_pkg::ADDR_STATUS, '0);
		end
	endtask

	// Counts edges on both clock pins over 40 cycles, sampled away from the clock edge
	task automatic watch;
		logic pm, pa;
		mt = 0;
		at = 0;
		@(negedge core_clk);
		pm = main_clk_out;
		pa = aux_out;
		repeat (40) begin
			@(negedge core_clk);
			if (main_clk_out !== pm) mt++;
			if (aux_out !== pa) at++;
			pm = main_clk_out;
			pa = aux_out;
		end
	endtask

	task automatic wrap_up;
		$display("Counts: %0d compared, %0d mismatched", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end

	initial begin
		#(30000 * 100);
		n_mismatch++;
		$display("Error watchdog expected finish seen timeout");
		wrap_up();
	end

	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		mode_req = 2'h0;
		sf_req = 1'b0;
		ref_run = 1'b1;
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, 8'(4 * i), '0);
			`CHK("ratio reset", smc_pkg::RATIO_RST, rd)
		end
		apb(1'b0, smc_pkg::ADDR_GLOBAL, '0);
		`CHK("global reset", 32'h0000_0008, rd)
		`CHK("ready", 1'b1, pready)
		apb(1'b0, 8'h20, '0);
		`CHK("unmapped err", 1'b1, err)
		`CHK("unmapped data", 32'h0000_0000, rd)
		$display("test reset done");

		for (int i = 0; i < 4; i++) apb(1'b1, 8'(4 * i), ratio[i]);
		apb(1'b1, smc_pkg::ADDR_MODAL, 32'h0000_3E90);
		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_00CC);
		apb(1'b0, smc_pkg::ADDR_MODAL, '0);
		`CHK("modal", 32'h0000_3E90, rd)
		pins(2'h1, 1'b0);
		pins(2'h2, 1'b0);
		pins(2'h3, 1'b0);
		apb(1'b0, smc_pkg::ADDR_STATUS, '0);
		`CHK("init done", 1'b1, rd[1])
		pins(2'h0, 1'b0);
		repeat (880) @(posedge core_clk);
		apb(1'b0, smc_pkg::ADDR_STATUS, '0);
		`CHK("early lock", 1'b0, rd[0])
		wait_lock();
		`CHK("status", 5'h03, rd[4:0])
		watch();
		`CHK("main clock", 1'b1, mt >= 16)
		`CHK("aux ref", 1'b1, at >= 8 && at <= 12)
		$display("test power up done");

		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				pins(2'(m), 1'(s));
				apb(1'b0, smc_pkg::ADDR_STATUS, '0);
				if (m != 0 || s != 0) `CHK("unlock", 1'b0, rd[0])
				`CHK("mode", {1'(s), 2'(m)}, rd[4:2])
				exp = (s != 0) ? ratio[m] >> (m + 1) : ratio[m];
				apb(1'b0, smc_pkg::ADDR_EFF, '0);
				`CHK("eff ratio", exp, rd)
				`CHK("frac n", {2'b00, exp}, frac_n_value)
			end
		end
		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_008C);
		repeat (3) @(posedge core_clk);
		`CHK("frac div4", {ratio[3] >> 4, 2'b00}, frac_n_value)
		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_00AC);
		repeat (3) @(posedge core_clk);
		`CHK("frac div2", {1'b0, ratio[3] >> 4, 1'b0}, frac_n_value)
		$display("test ratio done");

		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_00DC);
		pins(2'h0, 1'b1);
		wait_lock();
		watch();
		`CHK("aux forced synth", 1'b1, at >= 16)
		pins(2'h0, 1'b0);
		watch();
		`CHK("aux back to ref", 1'b1, at >= 8 && at <= 12)
		for (int j = 0; j < 4; j++) begin
			apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'(gcode[j]));
			pins(2'h0, 1'b1);
			`CHK("oe high pin", dis[j], {main_clk_oe_b, aux_oe_b})
			pins(2'h0, 1'b0);
			`CHK("oe low pin", 2'b00, {main_clk_oe_b, aux_oe_b})
		end
		$display("test routing done");

		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_00DC);
		pins(2'h2, 1'b0);
		`CHK("unlock push pull", 2'b10, {aux_out, aux_oe_b})
		watch();
		`CHK("main gated", 0, mt)
		wait_lock();
		repeat (3) @(posedge core_clk);
		`CHK("lock push pull", 2'b00, {aux_out, aux_oe_b})
		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_00DD);
		repeat (3) @(posedge core_clk);
		`CHK("lock open drain", 1'b1, aux_oe_b)
		@(posedge core_clk);
		ref_run <= 1'b0;
		repeat (30) @(posedge core_clk);
		apb(1'b0, smc_pkg::ADDR_STATUS, '0);
		`CHK("ref loss", 1'b0, rd[0])
		`CHK("unlock open drain", 2'b00, {aux_out, aux_oe_b})
		apb(1'b1, smc_pkg::ADDR_GLOBAL, 32'h0000_00DF);
		watch();
		`CHK("clock on unlock", 1'b1, mt >= 16)
		ref_run <= 1'b1;
		$display("test lock indicator done");
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
